// >>> rtl/mci_pkg.sv
// Purpose: Constants and types for the macro command interpreter.
// Assumes: APB slave at 200 MHz, one clock, async active-low reset.
// Notes:   All offsets are byte addresses of 32-bit words.
//
// Summary of operation
// RQ1: Command 17 stores predefined response; exception only on later mismatch.
// RQ2: Command 17 refused unless macro disabled and exception flag clear.
// RQ3: Auto-enable 01 enables macro after storing; 00 leaves it disabled.
// RQ4: Command 18 returns free bytes, free buffers, free source ids, active list; the code returns no active list.
// RQ5: Host issues memory report only after adapter configuration accepted.
// RQ6: Command 19 caps repetitive buffers, range 0..granted, default granted.
// RQ7: Per-secondary limit 1..granted, default min(2, granted).
// RQ8: Host allocates bandwidth only after unit initialized and granted.
// RQ9: Command 1A returns limits then repetitive and non-repetitive statistics.
// RQ10: Granted count and limits read zero until initialized.
// RQ11: All statistics counters saturate until explicitly reset.
// RQ12: Reset code 00 keeps counters; 01 clears and returns no statistics.
// RQ13: Byte counts are payload only; frame pairs exclude manager traffic.
// RQ14: Command 1B returns online flag, granted count, directive counts.
// RQ15: Network error counter counts crc, timeout, abort, serial losses.
// RQ16: Link-protocol error counter counts rejects, bad responses, sequence.
// RQ17: Connect and disconnect commands from manager counted separately.
// RQ18: Reconfiguration flag set on differing reinit; counter reset keeps it.
// RQ19: Disconnect permission reported 00 not granted, 01 granted.
// RQ20: Command 1C links trigger to action; trigger read starts action.
// RQ21: While linked, action runs only when trigger enabled and fired.
// RQ22: Disabling trigger disables action; queued action completes, reply dropped.
// RQ23: Option 00 unlinks; refused unless trigger is disabled.
// RQ24: Out-of-range bandwidth parameters give error, limits kept.
package mci_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD      = 8'h00;
	localparam logic [7:0] ADDR_ARG      = 8'h04;
	localparam logic [7:0] ADDR_RESULT   = 8'h08;
	localparam logic [7:0] ADDR_RDIDX    = 8'h0c;
	localparam logic [7:0] ADDR_RDDATA   = 8'h10;
	localparam logic [7:0] ADDR_NETEV    = 8'h14;
	localparam logic [7:0] ADDR_MACSTAT  = 8'h18;
	localparam logic [7:0] ADDR_RESPDATA = 8'h1c;

	// ----------------------------------------------------------------
	// Commands, codes and sizes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_INIT_RESP = 8'h17;
	localparam logic [7:0] CMD_MEM_USAGE = 8'h18;
	localparam logic [7:0] CMD_ALLOC_BW  = 8'h19;
	localparam logic [7:0] CMD_REPORT_BW = 8'h1a;
	localparam logic [7:0] CMD_STATUS    = 8'h1b;
	localparam logic [7:0] CMD_LINK      = 8'h1c;
	localparam logic [7:0] CODE_OFF      = 8'h00;
	localparam logic [7:0] CODE_ON       = 8'h01;
	localparam logic [7:0] DEF_PER_SEC   = 8'h02;
	localparam int         NUM_MACROS    = 16;
	localparam int         MACRO_AW      = 4;
	localparam int         RESP_WORDS    = 16;
	localparam int         MEM_AW        = 8;
	localparam logic [5:0] SRC_LIMIT     = 6'h20;
	localparam logic [15:0] MEM_BYTES    = 16'h4000;
	localparam int         NUM_STATS     = 12;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

	// Command result codes
	localparam logic [1:0] RES_IDLE = 2'h0;
	localparam logic [1:0] RES_OK   = 2'h1;
	localparam logic [1:0] RES_ERR  = 2'h2;

	// Statistic indexes
	localparam logic [3:0] ST_REP_PAIRS = 4'h0;
	localparam logic [3:0] ST_REP_TX    = 4'h1;
	localparam logic [3:0] ST_REP_RX    = 4'h2;
	localparam logic [3:0] ST_NRP_PAIRS = 4'h3;
	localparam logic [3:0] ST_NRP_TX    = 4'h4;
	localparam logic [3:0] ST_NRP_RX    = 4'h5;
	localparam logic [3:0] ST_SOLICIT   = 4'h6;
	localparam logic [3:0] ST_DIRRESP   = 4'h7;
	localparam logic [3:0] ST_NETERR    = 4'h8;
	localparam logic [3:0] ST_LNKERR    = 4'h9;
	localparam logic [3:0] ST_SNRM      = 4'ha;
	localparam logic [3:0] ST_DISC      = 4'hb;

	typedef enum logic [1:0] {
		MCI_IDLE,
		MCI_EXEC,
		MCI_STORE
	} mci_state_t;

endpackage

// >>> rtl/mci_resp_mem.sv
// Purpose: Macro response buffer storage, registered read.
// Assumes: Single clock, one write and one read port.
// Notes:   Contents are not reset.
module mci_resp_mem
	import mci_pkg::*;
(
	// Clock
	input  wire logic              pclk,
	// Write port
	input  wire logic              wr_en,
	input  wire logic [MEM_AW-1:0] wr_addr,
	input  wire logic [31:0]       wr_data,
	// Read port
	input  wire logic [MEM_AW-1:0] rd_addr,
	output logic      [31:0]       rd_data
);

	logic [31:0] mem [0:(1<<MEM_AW)-1];

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

// >>> rtl/mci_top.sv
// Purpose: Command interpreter for macro engine commands 17..1C.
// Assumes: Engine events arrive as one-cycle pulses on pclk.
// Notes:   Commands are written to CMD after ARG; result in RESULT.
module mci_top
	import mci_pkg::*;
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Network manager state
	input  wire logic        nm_init,
	input  wire logic [7:0]  nm_granted,
	input  wire logic        nm_reconfig,
	input  wire logic        online,
	input  wire logic        disc_permit,
	input  wire logic        cfg_accepted,
	// Traffic events
	input  wire logic        ev_frame_pair,
	input  wire logic        ev_repetitive,
	input  wire logic        ev_nm_frame,
	input  wire logic [7:0]  ev_tx_bytes,
	input  wire logic [7:0]  ev_rx_bytes,
	input  wire logic        ev_solicit,
	input  wire logic        ev_dir_resp,
	input  wire logic        ev_net_err,
	input  wire logic        ev_link_err,
	input  wire logic        ev_snrm,
	input  wire logic        ev_disc,
	// Macro engine events
	input  wire logic        trig_done,
	input  wire logic        action_queued,
	input  wire logic        action_done,
	input  wire logic [3:0]  macro_src,
	input  wire logic        macro_resp_diff,
	// Macro control outputs
	output logic [NUM_MACROS-1:0] macro_en,
	output logic [NUM_MACROS-1:0] macro_exc,
	output logic                  action_start,
	output logic                  action_drop,
	output logic [7:0]            rep_limit,
	output logic [7:0]            sec_limit
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [31:0] sat_add(input logic [31:0] a,
		input logic [7:0] b);
		logic [32:0] s;
		s = {1'b0, a} + {25'h0, b};
		sat_add = s[32] ? 32'hffff_ffff : s[31:0];
	endfunction

	function automatic logic [7:0] min8(input logic [7:0] a,
		input logic [7:0] b);
		min8 = (a < b) ? a : b;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	mci_state_t            state;
	logic [31:0]           arg;
	logic [7:0]            cmd;
	logic [1:0]            res_code;
	logic [31:0]           result;
	logic [3:0]            rd_idx;
	logic [31:0]           stats [0:NUM_STATS-1];
	logic [NUM_MACROS-1:0] exc_armed;
	logic                  linked;
	logic [MACRO_AW-1:0]   trig_id;
	logic [MACRO_AW-1:0]   act_id;
	logic                  act_pending;
	logic                  drop_pending;
	logic                  reconfig_flag;
	logic                  init_seen;
	logic [3:0]            st_cnt;
	logic [MEM_AW-1:0]     mem_waddr;
	logic [MEM_AW-1:0]     mem_raddr;
	logic [31:0]           mem_rdata;
	logic                  mem_wr;
	logic [NUM_MACROS-1:0] src_active;
	logic                  wr_go;
	logic                  rd_go;
	logic                  stat_clear;
	logic [MACRO_AW-1:0]   arg_buf;
	logic [MACRO_AW-1:0]   arg_b2;
	logic [7:0]            arg_p1;
	logic [7:0]            arg_p2;
	logic [7:0]            granted;

	assign wr_go   = psel && penable && pwrite;
	assign rd_go   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign arg_buf = arg[MACRO_AW-1:0];
	assign arg_b2  = arg[8+MACRO_AW-1:8];
	assign arg_p1  = arg[7:0];
	assign arg_p2  = arg[15:8];
	// RQ10 zero before init
	assign granted = nm_init ? nm_granted : 8'h00;

	// ----------------------------------------------------------------
	// APB write and command decode
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arg <= 32'h0;
			cmd <= 8'h0;
			rd_idx <= 4'h0;
			state <= MCI_IDLE;
			st_cnt <= 4'h0;
		end else begin
			if (wr_go && paddr == ADDR_ARG) begin
				arg <= pwdata;
			end else if (wr_go && paddr == ADDR_RDIDX) begin
				rd_idx <= pwdata[3:0];
			end
			case (state)
				MCI_IDLE: begin
					if (wr_go && paddr == ADDR_CMD) begin
						cmd <= pwdata[7:0];
						st_cnt <= 4'h0;
						state <= (pwdata[7:0] == CMD_INIT_RESP) ?
							MCI_STORE : MCI_EXEC;
					end
				end
				MCI_STORE: begin
					st_cnt <= st_cnt + 4'h1;
					if (st_cnt == 4'hf) begin
						state <= MCI_EXEC;
					end
				end
				default: begin
					state <= MCI_IDLE;
				end
			endcase
		end
	end

	// RQ1 response words come from the data port
	assign mem_wr = state == MCI_STORE && macro_en[arg_buf] == 1'b0 &&
		macro_exc[arg_buf] == 1'b0;
	assign mem_waddr = {arg_buf, st_cnt};

	logic [31:0] resp_word;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_word <= 32'h0;
		end else if (wr_go && paddr == ADDR_RESPDATA) begin
			resp_word <= pwdata;
		end
	end

	mci_resp_mem u_mem (
		.pclk    (pclk),
		.wr_en   (mem_wr),
		.wr_addr (mem_waddr),
		.wr_data (resp_word),
		.rd_addr (mem_raddr),
		.rd_data (mem_rdata)
	);
	assign mem_raddr = {arg_buf, rd_idx};

	// ----------------------------------------------------------------
	// Command execution, macro and link state
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_code <= RES_IDLE;
			result <= RESULT_RESET;
			macro_en <= '0;
			macro_exc <= '0;
			exc_armed <= '0;
			linked <= 1'b0;
			trig_id <= '0;
			act_id <= '0;
			rep_limit <= 8'h0;
			sec_limit <= 8'h0;
			init_seen <= 1'b0;
			src_active <= '0;
		end else begin
			init_seen <= nm_init;
			// RQ6 default limits on initialization
			if (nm_init && !init_seen) begin
				rep_limit <= nm_granted;
				sec_limit <= min8(DEF_PER_SEC, nm_granted);
			end else if (!nm_init) begin
				rep_limit <= 8'h0;
				sec_limit <= 8'h0;
			end
			// RQ20 trigger read fires action
			if (linked && trig_done && macro_en[trig_id]) begin
				macro_en[act_id] <= 1'b1;
			end
			if (linked && action_done) begin
				macro_en[act_id] <= 1'b0;
			end
			if (state == MCI_EXEC) begin
				res_code <= RES_OK;
				result <= {24'h0, cmd};
				case (cmd)
					CMD_INIT_RESP: begin
						// RQ2 refuse unless disabled and clear
						if (macro_en[arg_buf] || macro_exc[arg_buf]) begin
							res_code <= RES_ERR;
						end else begin
							exc_armed[arg_buf] <= 1'b1;
							src_active[arg_buf] <= 1'b1;
							result <= {12'h0, arg_buf, arg[23:16], cmd};
							// RQ3 auto-enable
							if (arg[15:8] == CODE_ON) begin
								macro_en[arg_buf] <= 1'b1;
							end
						end
					end
					CMD_MEM_USAGE: begin
						// RQ4 usage report
						result <= {16'(MEM_BYTES -
							{6'($countones(src_active)), 10'h0}), 2'h0,
							SRC_LIMIT - 6'($countones(src_active)),
							8'(NUM_MACROS - $countones(src_active))};
						if (!cfg_accepted) begin
							res_code <= RES_ERR;
						end
					end
					CMD_ALLOC_BW: begin
						// RQ24 range check keeps old limits
						if (!nm_init || arg_p1 > nm_granted ||
							arg_p2 == 8'h0 || arg_p2 > nm_granted) begin
							res_code <= RES_ERR;
						end else begin
							// RQ7 per-secondary limit
							rep_limit <= arg_p1;
							sec_limit <= arg_p2;
						end
					end
					CMD_REPORT_BW: begin
						// RQ9 limits header
						result <= {8'h0, granted, rep_limit, sec_limit};
					end
					CMD_STATUS: begin
						// RQ14 RQ19 status header
						result <= {6'h0, reconfig_flag, disc_permit,
							granted, 7'h0, online, cmd};
					end
					CMD_LINK: begin
						if (arg[23:16] == CODE_OFF) begin
							// RQ23 unlink only with trigger disabled
							if (macro_en[arg_buf]) begin
								res_code <= RES_ERR;
							end else begin
								linked <= 1'b0;
							end
						end else begin
							linked <= 1'b1;
							trig_id <= arg_buf;
							act_id <= arg_b2;
						end
					end
					default: begin
						res_code <= RES_ERR;
					end
				endcase
			end
			// RQ22 trigger disable takes action down
			if (linked && !macro_en[trig_id]) begin
				macro_en[act_id] <= 1'b0;
			end
			if (wr_go && paddr == ADDR_MACSTAT) begin
				macro_en <= macro_en & ~pwdata[15:0];
				macro_exc <= macro_exc & ~pwdata[31:16];
			end
			// RQ1 exception on mismatch; set wins over same-cycle clear
			if (macro_resp_diff && exc_armed[macro_src]) begin
				macro_exc[macro_src] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Action queue tracking
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_pending <= 1'b0;
			drop_pending <= 1'b0;
		end else begin
			if (action_queued) begin
				act_pending <= 1'b1;
			end else if (action_done) begin
				act_pending <= 1'b0;
			end
			// RQ22 response of queued action dropped
			if (action_done) begin
				drop_pending <= 1'b0;
			end else if (linked && act_pending && !macro_en[trig_id]) begin
				drop_pending <= 1'b1;
			end
		end
	end
	// RQ21 action only when trigger enabled and fired
	assign action_start = linked && trig_done && macro_en[trig_id];
	assign action_drop  = action_done && drop_pending;

	// ----------------------------------------------------------------
	// Statistics
	// ----------------------------------------------------------------
	// RQ12 code 01 clears
	assign stat_clear = state == MCI_EXEC && arg_p1 == CODE_ON &&
		(cmd == CMD_REPORT_BW || cmd == CMD_STATUS);

	logic [7:0] inc [0:NUM_STATS-1];
	always_comb begin
		for (int i = 0; i < NUM_STATS; i++) begin
			inc[i] = 8'h0;
		end
		// RQ13 payload only, manager frames excluded
		if (ev_frame_pair && !ev_nm_frame) begin
			inc[ev_repetitive ? ST_REP_PAIRS : ST_NRP_PAIRS] = 8'h1;
			inc[ev_repetitive ? ST_REP_TX : ST_NRP_TX] = ev_tx_bytes;
			inc[ev_repetitive ? ST_REP_RX : ST_NRP_RX] = ev_rx_bytes;
		end
		inc[ST_SOLICIT] = {7'h0, ev_solicit};
		inc[ST_DIRRESP] = {7'h0, ev_dir_resp};
		// RQ15 network errors
		inc[ST_NETERR] = {7'h0, ev_net_err};
		// RQ16 link-protocol errors
		inc[ST_LNKERR] = {7'h0, ev_link_err};
		// RQ17 connect and disconnect counts
		inc[ST_SNRM] = {7'h0, ev_snrm};
		inc[ST_DISC] = {7'h0, ev_disc};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_STATS; i++) begin
				stats[i] <= 32'h0;
			end
		end else begin
			for (int i = 0; i < NUM_STATS; i++) begin
				// RQ11 saturating counters
				stats[i] <= stat_clear ? 32'h0 : sat_add(stats[i], inc[i]);
			end
		end
	end

	// RQ18 reconfiguration flag, not cleared by counter reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reconfig_flag <= 1'b0;
		end else if (nm_reconfig) begin
			reconfig_flag <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// APB read
	// ----------------------------------------------------------------
	always_comb begin
		prdata = 32'h0;
		pslverr = 1'b0;
		if (paddr == ADDR_CMD) begin
			prdata = {20'h0, state, res_code, cmd};
		end else if (paddr == ADDR_ARG) begin
			prdata = arg;
		end else if (paddr == ADDR_RESULT) begin
			prdata = result;
		end else if (paddr == ADDR_RDIDX) begin
			prdata = {28'h0, rd_idx};
		end else if (paddr == ADDR_RDDATA) begin
			prdata = (rd_idx < 4'(NUM_STATS)) ? stats[rd_idx] : 32'h0;
		end else if (paddr == ADDR_NETEV) begin
			prdata = {16'h0, 8'(granted), 7'h0, linked};
		end else if (paddr == ADDR_MACSTAT) begin
			prdata = {macro_exc, macro_en};
		end else if (paddr == ADDR_RESPDATA) begin
			prdata = mem_rdata;
		end else if (psel) begin
			pslverr = rd_go || wr_go;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_stat_saturate: assert property (@(posedge pclk) disable iff (!presetn)
		(stats[ST_NETERR] == 32'hffff_ffff && !stat_clear) |=>
		stats[ST_NETERR] == 32'hffff_ffff) else $error("counter wrapped"); // RQ11
	a_reconfig_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		reconfig_flag |=> reconfig_flag) else $error("reconfig lost"); // RQ18
	a_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
		stat_clear |=> stats[ST_SNRM] == 32'h0) else $error("no clear"); // RQ12
	a_action_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(action_start && !action_done && state != MCI_EXEC &&
		!(wr_go && paddr == ADDR_MACSTAT)) |=> macro_en[act_id])
		else $error("action not started"); // RQ20
	a_init_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		(state == MCI_EXEC && cmd == CMD_INIT_RESP && macro_exc[arg_buf]) |=>
		res_code == RES_ERR) else $error("init accepted"); // RQ2
	a_bw_range: assert property (@(posedge pclk) disable iff (!presetn)
		(state == MCI_EXEC && cmd == CMD_ALLOC_BW && arg_p2 == 8'h0) |=>
		$stable(sec_limit) && res_code == RES_ERR)
		else $error("bad limit taken"); // RQ24
	a_zero_uninit: assert property (@(posedge pclk) disable iff (!presetn)
		!nm_init ##1 !nm_init |-> rep_limit == 8'h0 && sec_limit == 8'h0)
		else $error("limits not zero"); // RQ10
	a_unlink_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		(state == MCI_EXEC && cmd == CMD_LINK && arg[23:16] == CODE_OFF &&
		macro_en[arg_buf] && linked) |=> linked)
		else $error("unlinked while enabled"); // RQ23

endmodule

// >>> sim/mci_host.sv
// Purpose: Host model issuing APB requests to the interpreter.
// Assumes: Slave may add wait states; pready sampled at rising edges.
// Notes:   The bench calls xfer; released lines show inverted values.
module mci_host (
	// Clock
	input  wire logic        pclk,
	// APB request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	// APB answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// ------------------------------------------------------------
	// One transfer: setup, access until pready, then release
	// ------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r,
		output logic e, output logic ok);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		r  = prdata;
		e  = pslverr;
		ok = (pready === 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask
endmodule

// >>> sim/mci_top_bench.sv
// Purpose: Self-checking bench for the macro command interpreter.
// Assumes: Zero-wait APB slave; eight granted buffers.
// Notes:   Bandwidth cases run from a table, the rest by hand.
module mci_top_bench
	import mci_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [31:0] arg;
		logic [1:0]  res;
		logic [7:0]  rl;
		logic [7:0]  sl;
	} mci_row_t;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, nm_granted, ev_tx_bytes, ev_rx_bytes;
	logic [7:0]  rep_limit, sec_limit;
	logic [31:0] pwdata, prdata, rv;
	logic        nm_init, online, disc_permit, cfg_accepted, e;
	logic        action_start, action_drop;
	logic [3:0]  macro_src;
	logic [13:0] evv;
	logic [15:0] macro_en, macro_exc;
	logic [1:0]  res;
	int          err_total, comparisons;
	mci_row_t    rows [6] = '{
		'{32'h0000_0103, RES_OK, 8'h03, 8'h01},
		'{32'h0000_0800, RES_OK, 8'h00, 8'h08},
		'{32'h0000_0209, RES_ERR, 8'h00, 8'h08},
		'{32'h0000_0004, RES_ERR, 8'h00, 8'h08},
		'{32'h0000_0908, RES_ERR, 8'h00, 8'h08},
		'{32'h0000_0208, RES_OK, 8'h08, 8'h02}};
	logic [31:0] exp_st [12] = '{32'h1, 32'ha, 32'h14, 32'h1, 32'h0,
		32'h0, 32'h1, 32'h1, 32'h3, 32'h2, 32'h1, 32'h2};

	mci_host u_mci_host (
		.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr
	);

	mci_top u_mci_top (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .nm_init, .nm_granted,
		.nm_reconfig(evv[13]), .online, .disc_permit, .cfg_accepted,
		.ev_frame_pair(evv[0]), .ev_repetitive(evv[1]),
		.ev_nm_frame(evv[2]), .ev_tx_bytes, .ev_rx_bytes,
		.ev_solicit(evv[3]), .ev_dir_resp(evv[4]), .ev_net_err(evv[5]),
		.ev_link_err(evv[6]), .ev_snrm(evv[7]), .ev_disc(evv[8]),
		.trig_done(evv[9]), .action_queued(evv[10]),
		.action_done(evv[11]), .macro_src, .macro_resp_diff(evv[12]),
		.macro_en, .macro_exc, .action_start, .action_drop, .rep_limit,
		.sec_limit
	);

	always #2.5 pclk = ~pclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("Mismatches %0d in %0d checks", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		logic ok;
		u_mci_host.xfer(w, a, d, rv, e, ok);
		if (!ok) begin
			err_total++;
			conclude();
		end
	endtask

	task automatic cmd(input logic [7:0] code, input logic [31:0] arg);
		int n;
		bus(1'b1, ADDR_ARG, arg);
		bus(1'b1, ADDR_CMD, {24'h0, code});
		n = 0;
		do begin
			bus(1'b0, ADDR_CMD, 32'h0);
			n++;
		end while (rv[11:10] !== 2'h0 && n < 40);
		if (rv[11:10] !== 2'h0) begin
			err_total++;
			conclude();
		end
		res = rv[9:8];
	endtask

	task automatic settle();
		@(posedge pclk);
		#1;
	endtask

	task automatic pulse(input logic [13:0] v);
		@(posedge pclk);
		evv <= v;
		@(posedge pclk);
		evv <= 14'h0;
	endtask

	task automatic stats(input logic clr);
		for (int i = 0; i < NUM_STATS; i++) begin
			bus(1'b1, ADDR_RDIDX, 32'(i));
			bus(1'b0, ADDR_RDDATA, 32'h0);
			chk(rv, clr ? 32'h0 : exp_st[i]);
		end
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		nm_init = 1'b0;
		nm_granted = 8'h08;
		online = 1'b1;
		disc_permit = 1'b1;
		cfg_accepted = 1'b0;
		ev_tx_bytes = 8'h00;
		ev_rx_bytes = 8'h00;
		macro_src = 4'h0;
		evv = 14'h0;
		err_total = 0;
		comparisons = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		chk(32'(rep_limit), 32'h0);
		chk(32'(sec_limit), 32'h0);
		@(posedge pclk);
		cfg_accepted <= 1'b1;
		nm_init <= 1'b1;
		repeat (4) settle();
		chk(32'(rep_limit), 32'h8);
		chk(32'(sec_limit), 32'h2);
		cmd(CMD_MEM_USAGE, 32'h0);
		chk(32'(res), 32'(RES_OK));
		bus(1'b0, ADDR_RESULT, 32'h0);
		chk(rv, {MEM_BYTES, 2'h0, SRC_LIMIT, 8'(NUM_MACROS)});
		for (int i = 0; i < 6; i++) begin
			cmd(CMD_ALLOC_BW, rows[i].arg);
			settle();
			chk(32'(res), 32'(rows[i].res));
			chk(32'(rep_limit), 32'(rows[i].rl));
			chk(32'(sec_limit), 32'(rows[i].sl));
		end
		bus(1'b1, ADDR_RESPDATA, 32'h1234_5678);
		cmd(CMD_INIT_RESP, 32'h0000_0103);
		settle();
		chk(32'(res), 32'(RES_OK));
		chk(32'(macro_en), 32'h8);
		bus(1'b0, ADDR_RESULT, 32'h0);
		chk(rv, {12'h0, 4'h3, 8'h00, CMD_INIT_RESP});
		bus(1'b0, ADDR_RESPDATA, 32'h0);
		chk(rv, 32'h1234_5678);
		cmd(CMD_INIT_RESP, 32'h0000_0103);
		chk(32'(res), 32'(RES_ERR));
		cmd(CMD_INIT_RESP, 32'h0000_0005);
		settle();
		chk(32'(res), 32'(RES_OK));
		chk(32'(macro_en), 32'h8);
		macro_src <= 4'h3;
		pulse(14'h1000);
		settle();
		chk(32'(macro_exc), 32'h8);
		bus(1'b1, ADDR_MACSTAT, 32'h0000_0008);
		cmd(CMD_INIT_RESP, 32'h0000_0003);
		chk(32'(res), 32'(RES_ERR));
		bus(1'b1, ADDR_MACSTAT, 32'h0008_0000);
		cmd(CMD_INIT_RESP, 32'h0000_0103);
		settle();
		chk(32'(res), 32'(RES_OK));
		chk(32'(macro_exc), 32'h0);
		cmd(CMD_LINK, 32'h0001_0603);
		chk(32'(res), 32'(RES_OK));
		cmd(CMD_LINK, 32'h0000_0603);
		chk(32'(res), 32'(RES_ERR));
		@(posedge pclk);
		evv <= 14'h0200;
		#1;
		chk(32'(action_start), 32'h1);
		@(posedge pclk);
		evv <= 14'h0;
		pulse(14'h0400);
		bus(1'b1, ADDR_MACSTAT, 32'h0000_0008);
		@(posedge pclk);
		evv <= 14'h0800;
		#1;
		chk(32'(action_drop), 32'h1);
		@(posedge pclk);
		evv <= 14'h0200;
		#1;
		chk(32'(action_start), 32'h0);
		@(posedge pclk);
		evv <= 14'h0;
		cmd(CMD_LINK, 32'h0000_0603);
		chk(32'(res), 32'(RES_OK));
		ev_tx_bytes <= 8'h0a;
		ev_rx_bytes <= 8'h14;
		pulse(14'h0003);
		ev_tx_bytes <= 8'h00;
		ev_rx_bytes <= 8'h00;
		pulse(14'h0005);
		pulse(14'h0001);
		repeat (3) pulse(14'h0020);
		repeat (2) pulse(14'h0040);
		pulse(14'h0080);
		repeat (2) pulse(14'h0100);
		pulse(14'h0008);
		pulse(14'h0010);
		cmd(CMD_REPORT_BW, 32'h0);
		chk(32'(res), 32'(RES_OK));
		bus(1'b0, ADDR_RESULT, 32'h0);
		chk(rv, 32'h0008_0802);
		stats(1'b0);
		pulse(14'h2000);
		cmd(CMD_STATUS, 32'h1);
		chk(32'(res), 32'(RES_OK));
		bus(1'b0, ADDR_RESULT, 32'h0);
		chk(rv, 32'h0308_011b);
		stats(1'b1);
		bus(1'b0, 8'hf0, 32'h0);
		chk(32'(e), 32'h1);
		// Mid-run reset: limits drop, then defaults return
		@(posedge pclk);
		presetn <= 1'b0;
		settle();
		chk(32'(rep_limit), 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		settle();
		chk(32'(rep_limit), 32'h8);
		chk(32'(sec_limit), 32'h2);
		conclude();
	end
endmodule
